/* File: common/updc_pkg.sv */
// constants shared by the pulse counter bank and its channel counter
// assumes a 100 MHz system clock and a word-wide register port
package updc_pkg;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int NUM_CH = 8;
    localparam int SEL_W  = 4;
    localparam int CNT_W  = 32;
    localparam int ADDR_W = 8;
    localparam logic [CNT_W-1:0] CNT_MAX = 32'hFFFFFFFF;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_SEL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CMD    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CFG    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_TMO    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STAT   = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_IRQ    = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h20;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int CMD_START = 0;
    localparam int CMD_STOP  = 1;
    localparam int CMD_CLEAR = 2;
    localparam int CFG_FALL  = 0;
    localparam int STAT_DIR  = 0;
    localparam int STAT_STL  = 1;
    localparam int STAT_RUN  = 2;
    localparam int STAT_ERR  = 3;
    localparam int IRQ_STL   = 0;
    localparam int IRQ_ERR   = 1;
    localparam int IRQ_W     = 2;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_RST  = 4'h0;
    localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int  CLK_HZ      = 100_000_000;
    localparam int  TICK_HZ     = 1_000_000;
    localparam int  TICK_CYC    = CLK_HZ / TICK_HZ;
    localparam int  TICK_W      = 7;
    localparam real STALL_DEF_S = 0.05;
    localparam logic [CNT_W-1:0] TMO_RST =
        32'(int'(STALL_DEF_S * TICK_HZ));

endpackage

/* File: hdl/chan_counter.sv */
// one up/down pulse counting channel with period and stall tracking
// assumes sources are asynchronous pins and tick is a 1 us enable pulse
`timescale 1ns/1ns
module chan_counter (
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rstn,
    // pulse sources
    input  wire logic                        up_src,
    input  wire logic                        down_src,
    // timebase
    input  wire logic                        tick,
    // control from the register block
    input  wire logic                        start,
    input  wire logic                        stop,
    input  wire logic                        clear,
    input  wire logic                        cfg_wr,
    input  wire logic                        tmo_wr,
    input  wire logic [updc_pkg::CNT_W-1:0]  wdata,
    // state to the register block
    output logic [updc_pkg::CNT_W-1:0]       count,
    output logic [updc_pkg::CNT_W-1:0]       period,
    output logic [updc_pkg::CNT_W-1:0]       timeout,
    output logic                             dir,
    output logic                             stalled,
    output logic                             running,
    output logic                             falling,
    output logic                             stall_evt
);

    typedef struct packed {
        logic [1:0]                  s1;
        logic [1:0]                  s2;
        logic [1:0]                  prev;
        logic                        run;
        logic                        fall;
        logic [updc_pkg::CNT_W-1:0]  tmo;
        logic [updc_pkg::CNT_W-1:0]  cnt;
        logic                        dir;
        logic [updc_pkg::CNT_W-1:0]  elap;
        logic [updc_pkg::CNT_W-1:0]  per;
        logic                        seen;
        logic                        stall;
        logic                        evt;
    } ch_s;

    ch_s q;
    ch_s d;
    logic [1:0] edg;
    logic       up_p;
    logic       dn_p;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d      = q;
        d.evt  = 1'b0;
        d.s1   = {down_src, up_src};
        d.s2   = q.s1;
        d.prev = q.s2;
        edg    = q.fall ? (q.prev & ~q.s2) : (q.s2 & ~q.prev);
        up_p   = q.run & edg[0] & ~edg[1];
        dn_p   = q.run & edg[1] & ~edg[0];
        if (start) begin
            d.run = 1'b1;
        end
        if (stop) begin
            d.run = 1'b0;
        end
        if (cfg_wr) begin
            d.fall = wdata[updc_pkg::CFG_FALL];
        end
        if (tmo_wr) begin
            d.tmo = wdata;
        end
        // free running 1 us timebase measures time since last pulse
        if (tick && q.elap != updc_pkg::CNT_MAX) begin
            d.elap = q.elap + 32'h00000001;
        end
        if (up_p || dn_p) begin
            // wraps past the maximum with no error flag
            d.cnt   = up_p ? q.cnt + 32'h00000001
                           : q.cnt - 32'h00000001;
            d.dir   = up_p;
            d.elap  = '0;
            d.seen  = 1'b1;
            d.stall = 1'b0;
            if (q.seen) begin
                d.per = q.elap;
            end
        end else if (!q.stall && q.elap >= q.tmo) begin
            d.stall = 1'b1;
            d.evt   = 1'b1;
        end
        if (clear) begin
            d.cnt  = '0;
            d.elap = '0;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            q     <= '0;
            q.tmo <= updc_pkg::TMO_RST;
        end else begin
            q <= d;
        end
    end

    assign count     = q.cnt;
    assign period    = q.per;
    assign timeout   = q.tmo;
    assign dir       = q.dir;
    assign stalled   = q.stall;
    assign running   = q.run;
    assign falling   = q.fall;
    assign stall_evt = q.evt;

endmodule // chan_counter

/* File: hdl/up_down_pulse_counter.sv */
// bank of eight up/down pulse counters behind a simple register port
// assumes a single 100 MHz clock and asynchronous sensor inputs
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns

module up_down_pulse_counter (
    // clock and reset
    input  wire logic                         mclk,
    input  wire logic                         rstn,
    // sensor sources
    input  wire logic [updc_pkg::NUM_CH-1:0]  up_src,
    input  wire logic [updc_pkg::NUM_CH-1:0]  down_src,
    // register port
    input  wire logic [updc_pkg::ADDR_W-1:0]  addr,
    input  wire logic [updc_pkg::CNT_W-1:0]   wdata,
    input  wire logic                         wr,
    input  wire logic                         rd,
    output logic      [updc_pkg::CNT_W-1:0]   rdata,
    // interrupt
    output logic                              irq
);

    typedef struct packed {
        logic [updc_pkg::TICK_W-1:0] div;
        logic                        tick;
        logic [updc_pkg::SEL_W-1:0]  sel;
        logic [updc_pkg::IRQ_W-1:0]  ists;
        logic [updc_pkg::IRQ_W-1:0]  mask;
        logic [updc_pkg::CNT_W-1:0]  rdat;
        logic [updc_pkg::CNT_W-1:0]  snap_per;
        logic                        snap_dir;
        logic                        snap_stl;
        logic                        snap_run;
        logic                        err;
    } top_s;

    top_s q;
    top_s d;

    logic [updc_pkg::CNT_W-1:0] cnt_a [updc_pkg::NUM_CH];
    logic [updc_pkg::CNT_W-1:0] per_a [updc_pkg::NUM_CH];
    logic [updc_pkg::CNT_W-1:0] tmo_a [updc_pkg::NUM_CH];
    logic [updc_pkg::NUM_CH-1:0] dir_v;
    logic [updc_pkg::NUM_CH-1:0] stl_v;
    logic [updc_pkg::NUM_CH-1:0] run_v;
    logic [updc_pkg::NUM_CH-1:0] fall_v;
    logic [updc_pkg::NUM_CH-1:0] evt_v;
    logic [updc_pkg::NUM_CH-1:0] hit;
    logic                        sel_ok;
    logic                        ch_reg;
    logic                        err_acc;
    logic [2:0]                  ch;
    logic [updc_pkg::IRQ_W-1:0]  ev;
    logic [updc_pkg::IRQ_W-1:0]  clr;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    assign ch     = q.sel[2:0];
    assign sel_ok = (q.sel < 4'(updc_pkg::NUM_CH));
    assign ch_reg = (addr == updc_pkg::OFS_CMD)
                  || (addr == updc_pkg::OFS_CFG)
                  || (addr == updc_pkg::OFS_TMO)
                  || (addr == updc_pkg::OFS_COUNT)
                  || (addr == updc_pkg::OFS_PERIOD)
                  || (addr == updc_pkg::OFS_STAT);
    assign err_acc = (wr || rd) && ch_reg && !sel_ok;

    // ----------------------------------------------------------------
    // channels
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < updc_pkg::NUM_CH; gi++) begin : g_ch
            assign hit[gi] = wr && sel_ok && (ch == 3'(gi));
            chan_counter u_ch (
                .mclk      (mclk),
                .rstn      (rstn),
                .up_src    (up_src[gi]),
                .down_src  (down_src[gi]),
                .tick      (q.tick),
                .start     (hit[gi] && addr == updc_pkg::OFS_CMD
                            && wdata[updc_pkg::CMD_START]),
                .stop      (hit[gi] && addr == updc_pkg::OFS_CMD
                            && wdata[updc_pkg::CMD_STOP]),
                .clear     (hit[gi] && addr == updc_pkg::OFS_CMD
                            && wdata[updc_pkg::CMD_CLEAR]),
                .cfg_wr    (hit[gi] && addr == updc_pkg::OFS_CFG),
                .tmo_wr    (hit[gi] && addr == updc_pkg::OFS_TMO),
                .wdata     (wdata),
                .count     (cnt_a[gi]),
                .period    (per_a[gi]),
                .timeout   (tmo_a[gi]),
                .dir       (dir_v[gi]),
                .stalled   (stl_v[gi]),
                .running   (run_v[gi]),
                .falling   (fall_v[gi]),
                .stall_evt (evt_v[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d      = q;
        d.rdat = '0;
        clr    = '0;
        // 1 us enable pulse from the system clock
        d.tick = 1'b0;
        if (q.div == 7'(updc_pkg::TICK_CYC - 1)) begin
            d.div  = '0;
            d.tick = 1'b1;
        end else begin
            d.div = q.div + 7'h01;
        end
        if (wr && addr == updc_pkg::OFS_SEL) begin
            d.sel = wdata[updc_pkg::SEL_W-1:0];
        end
        if (wr && addr == updc_pkg::OFS_MASK) begin
            d.mask = wdata[updc_pkg::IRQ_W-1:0];
        end
        if (err_acc) begin
            d.err = 1'b1;
        end else if ((wr || rd) && ch_reg) begin
            d.err = 1'b0;
        end
        if (rd) begin
            case (addr)
                updc_pkg::OFS_SEL: begin
                    d.rdat = {28'h0000000, q.sel};
                end
                updc_pkg::OFS_CFG: begin
                    d.rdat = sel_ok ? {31'h00000000, fall_v[ch]} : '0;
                end
                updc_pkg::OFS_TMO: begin
                    d.rdat = sel_ok ? tmo_a[ch] : '0;
                end
                updc_pkg::OFS_COUNT: begin
                    if (sel_ok) begin
                        d.rdat     = cnt_a[ch];
                        d.snap_per = per_a[ch];
                        d.snap_dir = dir_v[ch];
                        d.snap_stl = stl_v[ch];
                        d.snap_run = run_v[ch];
                    end
                end
                updc_pkg::OFS_PERIOD: begin
                    d.rdat = sel_ok ? q.snap_per : '0;
                end
                updc_pkg::OFS_STAT: begin
                    d.rdat = '0;
                    d.rdat[updc_pkg::STAT_ERR] = q.err;
                    if (sel_ok) begin
                        d.rdat[updc_pkg::STAT_DIR] = q.snap_dir;
                        d.rdat[updc_pkg::STAT_STL] = q.snap_stl;
                        d.rdat[updc_pkg::STAT_RUN] = q.snap_run;
                    end
                end
                updc_pkg::OFS_IRQ: begin
                    d.rdat = {30'h00000000, q.ists};
                    clr    = q.ists;
                end
                updc_pkg::OFS_MASK: begin
                    d.rdat = {30'h00000000, q.mask};
                end
                default: begin
                    d.rdat = '0;
                end
            endcase
        end
        // an event in the clearing cycle stays set
        ev                   = '0;
        ev[updc_pkg::IRQ_STL] = |evt_v;
        ev[updc_pkg::IRQ_ERR] = err_acc;
        d.ists = (q.ists & ~clr) | ev;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            q      <= '0;
            q.sel  <= updc_pkg::SEL_RST;
            q.mask <= updc_pkg::MASK_RST;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rdat;
    assign irq   = |(q.ists & q.mask);

endmodule // up_down_pulse_counter

/* File: sim/updc_asserts.sv */
// assertion checker for the pulse counter bank register port
// assumes it is bound to up_down_pulse_counter and sees only its ports
`timescale 1ns/1ns
module updc_asserts (
    // clock and reset
    input wire logic                        mclk,
    input wire logic                        rstn,
    // register port
    input wire logic [updc_pkg::ADDR_W-1:0] addr,
    input wire logic [updc_pkg::CNT_W-1:0]  wdata,
    input wire logic                        wr,
    input wire logic                        rd,
    input wire logic [updc_pkg::CNT_W-1:0]  rdata,
    // interrupt
    input wire logic                        irq
);
    // ------------------------------------------------------------
    // shadow of the writable registers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0]       sel;
        logic [1:0]       mask;
        logic [7:0]       fall;
        logic [7:0][31:0] tmo;
    } shadow_s;
    shadow_s s_q;
    shadow_s s_d;
    logic    ok;
    assign ok = !s_q.sel[3];
    always_comb begin
        s_d = s_q;
        if (wr && addr == updc_pkg::OFS_SEL)
            s_d.sel = wdata[3:0];
        if (wr && addr == updc_pkg::OFS_MASK)
            s_d.mask = wdata[1:0];
        if (wr && ok && addr == updc_pkg::OFS_CFG)
            s_d.fall[s_q.sel[2:0]] = wdata[0];
        if (wr && ok && addr == updc_pkg::OFS_TMO)
            s_d.tmo[s_q.sel[2:0]] = wdata;
    end
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            s_q <= '{sel: updc_pkg::SEL_RST, mask: updc_pkg::MASK_RST,
                     fall: 8'h00, tmo: {8{updc_pkg::TMO_RST}}};
        end else begin
            s_q <= s_d;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_idle_zero;
        !rd |=> rdata == 32'h0;
    endproperty
    a_idle_zero: assert property (p_idle_zero)
        else $error("read data not zero outside a read answer");
    property p_unmapped;
        rd && addr > updc_pkg::OFS_MASK |=> rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned data");
    property p_cmd_rd;
        rd && addr == updc_pkg::OFS_CMD |=> rdata == 32'h0;
    endproperty
    a_cmd_rd: assert property (p_cmd_rd)
        else $error("command register read not zero");
    property p_sel_rb;
        rd && addr == updc_pkg::OFS_SEL |=> rdata == {28'h0, s_q.sel};
    endproperty
    a_sel_rb: assert property (p_sel_rb)
        else $error("channel select readback wrong");
    property p_irq_mask;
        irq |-> s_q.mask != 2'h0;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt high with all sources masked");
    property p_cfg_rb;
        rd && ok && addr == updc_pkg::OFS_CFG
            |=> rdata == {31'h0, s_q.fall[s_q.sel[2:0]]};
    endproperty
    a_cfg_rb: assert property (p_cfg_rb)
        else $error("edge mode readback wrong");
    property p_tmo_rb;
        rd && ok && addr == updc_pkg::OFS_TMO
            |=> rdata == s_q.tmo[s_q.sel[2:0]];
    endproperty
    a_tmo_rb: assert property (p_tmo_rb)
        else $error("stall timeout readback wrong");
    property p_bad_cnt;
        rd && !ok && (addr == updc_pkg::OFS_COUNT
            || addr == updc_pkg::OFS_PERIOD) |=> rdata == 32'h0;
    endproperty
    a_bad_cnt: assert property (p_bad_cnt)
        else $error("invalid channel returned a count");
    property p_bad_stat;
        rd && !ok && addr == updc_pkg::OFS_STAT
            |=> (rdata & 32'hFFFFFFF7) == 32'h0;
    endproperty
    a_bad_stat: assert property (p_bad_stat)
        else $error("invalid channel status shows more than error");
endmodule // updc_asserts

bind up_down_pulse_counter updc_asserts chk (.mclk(mclk), .rstn(rstn),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

/* File: sim/pulse_sensor.sv */
// behavioural model of the pulse sensors on the up and down lines
// assumes the bench calls its tasks; lines idle low between pulses
`timescale 1ns/1ns
module pulse_sensor (
    // clock
    input  wire logic                    mclk,
    // sensor lines
    output logic [updc_pkg::NUM_CH-1:0]  up_src,
    output logic [updc_pkg::NUM_CH-1:0]  down_src
);
    initial begin
        up_src = '0;
        down_src = '0;
    end
    // set one line to a level and hold it for some cycles
    task automatic level(input int ch, input bit up, input bit val,
                         input int hold);
        @(posedge mclk);
        if (up)
            up_src[ch] <= val;
        else
            down_src[ch] <= val;
        repeat (hold) @(posedge mclk);
    endtask
    // one pulse on the up or down line of a channel
    task automatic pulse(input int ch, input bit up);
        level(ch, up, 1'b1, 6);
        level(ch, up, 1'b0, 6);
    endtask
endmodule // pulse_sensor

/* File: sim/tb_top.sv */
// self-checking bench for the pulse counter bank
// assumes the checker binds itself and the sensor model drives the pins
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    fail_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
    end end
module tb_top;
    logic                        mclk;
    logic                        rstn;
    logic [updc_pkg::NUM_CH-1:0] up_src;
    logic [updc_pkg::NUM_CH-1:0] down_src;
    logic [7:0]                  addr;
    logic [31:0]                 wdata;
    logic [31:0]                 rdata;
    logic [31:0]                 v;
    logic                        wr;
    logic                        rd;
    logic                        irq;
    int                          fail_count;
    int                          cmp_count;
    int                          i;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } row_s;
    row_s rows [13] = '{
        '{1'b0, updc_pkg::OFS_SEL, 32'h0, 32'h0},
        '{1'b0, updc_pkg::OFS_CFG, 32'h0, 32'h0},
        '{1'b0, updc_pkg::OFS_TMO, 32'h0, updc_pkg::TMO_RST},
        '{1'b0, updc_pkg::OFS_MASK, 32'h0, 32'h0},
        '{1'b0, updc_pkg::OFS_CMD, 32'h0, 32'h0},
        '{1'b0, updc_pkg::OFS_COUNT, 32'h0, 32'h0},
        '{1'b0, updc_pkg::OFS_PERIOD, 32'h0, 32'h0},
        '{1'b0, updc_pkg::OFS_IRQ, 32'h0, 32'h0},
        '{1'b1, 8'h24, 32'hA5, 32'h0},
        '{1'b1, updc_pkg::OFS_CFG, 32'h1, 32'h1},
        '{1'b1, updc_pkg::OFS_CFG, 32'h0, 32'h0},
        '{1'b1, updc_pkg::OFS_TMO, 32'h5, 32'h5},
        '{1'b1, updc_pkg::OFS_MASK, 32'h3, 32'h3}};

    up_down_pulse_counter dut (.mclk(mclk), .rstn(rstn), .up_src(up_src),
        .down_src(down_src), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq));
    pulse_sensor sensor (.mclk(mclk), .up_src(up_src), .down_src(down_src));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string n, input logic [7:0] a,
                          input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
        `CHK(n, e, v)
    endtask
    task automatic do_reset();
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        do_reset();
        foreach (rows[k]) begin
            if (rows[k].w)
                reg_wr(rows[k].a, rows[k].d);
            rd_chk("row", rows[k].a, rows[k].e);
        end
        $display("test registers done");
        sensor.pulse(0, 1'b1);
        rd_chk("held", updc_pkg::OFS_COUNT, 32'h0);
        reg_wr(updc_pkg::OFS_CMD, 32'h1);
        repeat (3) sensor.pulse(0, 1'b1);
        rd_chk("up", updc_pkg::OFS_COUNT, 32'h3);
        rd_chk("kept", updc_pkg::OFS_COUNT, 32'h3);
        rd_chk("dir up", updc_pkg::OFS_STAT, 32'h5);
        sensor.pulse(0, 1'b0);
        rd_chk("down", updc_pkg::OFS_COUNT, 32'h2);
        rd_chk("dir down", updc_pkg::OFS_STAT, 32'h4);
        reg_wr(updc_pkg::OFS_CMD, 32'h4);
        rd_chk("clear", updc_pkg::OFS_COUNT, 32'h0);
        sensor.pulse(0, 1'b1);
        rd_chk("after clear", updc_pkg::OFS_COUNT, 32'h1);
        repeat (2) sensor.pulse(0, 1'b0);
        rd_chk("under", updc_pkg::OFS_COUNT, 32'hFFFFFFFF);
        sensor.pulse(0, 1'b1);
        rd_chk("wrap", updc_pkg::OFS_COUNT, 32'h0);
        sensor.pulse(0, 1'b1);
        $display("test count done");
        reg_wr(updc_pkg::OFS_SEL, 32'h1);
        reg_wr(updc_pkg::OFS_CFG, 32'h1);
        reg_wr(updc_pkg::OFS_CMD, 32'h1);
        sensor.level(1, 1'b1, 1'b1, 8);
        rd_chk("rise ignored", updc_pkg::OFS_COUNT, 32'h0);
        sensor.level(1, 1'b1, 1'b0, 8);
        rd_chk("fall counted", updc_pkg::OFS_COUNT, 32'h1);
        reg_wr(updc_pkg::OFS_SEL, 32'h0);
        $display("test edge done");
        rd_chk("irq flush", updc_pkg::OFS_IRQ, 32'h0);
        sensor.pulse(0, 1'b1);
        // counted edges 301 cycles apart span exactly three 1 us ticks
        repeat (287) @(posedge mclk);
        sensor.pulse(0, 1'b1);
        rd_chk("snap", updc_pkg::OFS_COUNT, 32'h3);
        rd_chk("period", updc_pkg::OFS_PERIOD, 32'h3);
        `CHK("period range", 1'b1, v >= 32'h2 && v <= 32'h4)
        rd_chk("unstalled", updc_pkg::OFS_STAT, 32'h5);
        for (i = 0; i < 2000 && irq !== 1'b1; i++) @(posedge mclk);
        if (i == 2000) begin
            fail_count++;
            print_verdict();
        end
        `CHK("stall delay", 1'b1, i > 300)
        rd_chk("stall snap", updc_pkg::OFS_COUNT, 32'h3);
        rd_chk("stalled", updc_pkg::OFS_STAT, 32'h7);
        rd_chk("stall irq", updc_pkg::OFS_IRQ, 32'h1);
        `CHK("irq low", 1'b0, irq)
        sensor.pulse(0, 1'b1);
        rd_chk("restart", updc_pkg::OFS_COUNT, 32'h4);
        rd_chk("unstall", updc_pkg::OFS_STAT, 32'h5);
        reg_wr(updc_pkg::OFS_CMD, 32'h2);
        sensor.pulse(0, 1'b1);
        rd_chk("stopped", updc_pkg::OFS_COUNT, 32'h4);
        $display("test stall done");
        reg_wr(updc_pkg::OFS_SEL, 32'h8);
        reg_wr(updc_pkg::OFS_TMO, 32'h7);
        rd_chk("bad count", updc_pkg::OFS_COUNT, 32'h0);
        rd_chk("bad stat", updc_pkg::OFS_STAT, 32'h8);
        `CHK("err irq", 1'b1, irq)
        rd_chk("err status", updc_pkg::OFS_IRQ, 32'h2);
        reg_wr(updc_pkg::OFS_SEL, 32'h0);
        rd_chk("tmo kept", updc_pkg::OFS_TMO, 32'h5);
        $display("test index done");
        do_reset();
        sensor.pulse(0, 1'b1);
        rd_chk("reset count", updc_pkg::OFS_COUNT, 32'h0);
        $display("test reset done");
        print_verdict();
    end
endmodule // tb_top
